// *** common/acr_defs.svh ***
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH
`define ACR_OFF_CTRL2      12'h008
`define ACR_RESET_CTRL2    32'h0000_0000
`define ACR_WMASK_CTRL2    32'h00fe_f907
`define ACR_BIT_SENSOR     23
`define ACR_BIT_RSOFT      22
`define ACR_BIT_JSOFT      21
`define ACR_BIT_REXT       20
`define ACR_POS_RSEL       17
`define ACR_BIT_JEXT       15
`define ACR_POS_JSEL       12
`define ACR_BIT_ALIGN      11
`define ACR_BIT_DMA        8
`define ACR_BIT_CAL        2
`define ACR_BIT_CONT       1
`define ACR_BIT_POWER      0
`define ACR_SEL_SOFT       3'h7
`define ACR_HTRANS_NONSEQ  2'h2
`endif

// *** common/acr_pkg.sv ***
package acr_pkg;
   typedef struct packed {
      logic       sensor_ref_enable;
      logic       regular_soft_start;
      logic       injected_soft_start;
      logic       regular_ext_trig_enable;
      logic [2:0] regular_trigger_select;
      logic       injected_ext_trig_enable;
      logic [2:0] injected_trigger_select;
      logic       result_align_left;
      logic       dma_request_enable;
      logic       calibrate_start;
      logic       continuous_mode;
      logic       converter_power;
   } acr_ctrl_t;

   typedef struct packed {
      logic [7:0] regular_src;
      logic [7:0] injected_src;
   } acr_trig_t;

   typedef struct packed {
      logic        addr_valid;
      logic        addr_write;
      logic [11:0] addr;
   } acr_bus_t;
endpackage

// *** core/acr_sync.sv ***
`timescale 1ns/1ps
module acr_sync
   import acr_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } acr_sync_st_t;

   acr_sync_st_t st_q;
   acr_sync_st_t st_d;

   always_comb begin
      st_d      = st_q;
      st_d.meta = async_in;
      st_d.sync = st_q.meta;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_out = st_q.sync;
endmodule

// *** core/acr_trig_sel.sv ***
`timescale 1ns/1ps
`include "acr_defs.svh"
module acr_trig_sel
   import acr_pkg::*;
(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic [7:0] src,
   input  wire logic [2:0] sel,
   input  wire logic       ext_enable,
   output logic            fire
);
   // rising-edge detect on the synchronised sources; code 7 is software only
   typedef struct packed {
      logic [7:0] prev;
      logic       fire;
   } acr_ts_st_t;

   acr_ts_st_t st_q;
   acr_ts_st_t st_d;

   always_comb begin
      st_d      = st_q;
      st_d.prev = src;
      st_d.fire = ext_enable && (sel != `ACR_SEL_SOFT) && src[sel] && !st_q.prev[sel];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign fire = st_q.fire;
endmodule

// *** core/acr_ctrl2.sv ***
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
`include "acr_defs.svh"
module acr_ctrl2
   import acr_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [7:0]  regular_trig_in,
   input  wire logic [7:0]  injected_trig_in,
   input  wire logic        regular_conv_begin,
   input  wire logic        injected_conv_begin,
   input  wire logic        calibration_done,
   output logic             sensor_ref_on,
   output logic             converter_powered,
   output logic             power_down,
   output logic             regular_start,
   output logic             injected_start,
   output logic             calibrate_go,
   output logic             abort,
   output logic             continuous,
   output logic             align_left,
   output logic             dma_enable
);
   typedef struct packed {
      acr_ctrl_t   ctrl;
      acr_bus_t    bus;
      logic [31:0] rdata;
      logic        sensor_ref_on;
      logic        powered;
      logic        power_down;
      logic        reg_start;
      logic        inj_start;
      logic        cal_go;
      logic        abort;
      logic        cont;
      logic        align;
      logic        dma;
   } acr_st_t;

   acr_st_t st_q;
   acr_st_t st_d;

   logic [7:0] reg_src_s;
   logic [7:0] inj_src_s;
   logic       reg_ext_fire;
   logic       inj_ext_fire;

   // ************************************************************
   // trigger sources: pins, so two flops first
   // ************************************************************
   acr_sync #(.WIDTH(16)) u_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in ({regular_trig_in, injected_trig_in}),
      .sync_out ({reg_src_s, inj_src_s})
   );

   acr_trig_sel u_reg_sel (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .src        (reg_src_s),
      .sel        (st_q.ctrl.regular_trigger_select),
      .ext_enable (st_q.ctrl.regular_ext_trig_enable),
      .fire       (reg_ext_fire)
   );

   acr_trig_sel u_inj_sel (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .src        (inj_src_s),
      .sel        (st_q.ctrl.injected_trigger_select),
      .ext_enable (st_q.ctrl.injected_ext_trig_enable),
      .fire       (inj_ext_fire)
   );

   function automatic logic [31:0] pack_ctrl(input acr_ctrl_t c);
      logic [31:0] w;
      w                                    = '0;
      w[`ACR_BIT_SENSOR]                   = c.sensor_ref_enable;
      w[`ACR_BIT_RSOFT]                    = c.regular_soft_start;
      w[`ACR_BIT_JSOFT]                    = c.injected_soft_start;
      w[`ACR_BIT_REXT]                     = c.regular_ext_trig_enable;
      w[`ACR_POS_RSEL +: 3]                = c.regular_trigger_select;
      w[`ACR_BIT_JEXT]                     = c.injected_ext_trig_enable;
      w[`ACR_POS_JSEL +: 3]                = c.injected_trigger_select;
      w[`ACR_BIT_ALIGN]                    = c.result_align_left;
      w[`ACR_BIT_DMA]                      = c.dma_request_enable;
      w[`ACR_BIT_CAL]                      = c.calibrate_start;
      w[`ACR_BIT_CONT]                     = c.continuous_mode;
      w[`ACR_BIT_POWER]                    = c.converter_power;
      return w;
   endfunction

   function automatic acr_ctrl_t unpack_ctrl(input logic [31:0] w);
      acr_ctrl_t c;
      c.sensor_ref_enable        = w[`ACR_BIT_SENSOR];
      c.regular_soft_start       = w[`ACR_BIT_RSOFT];
      c.injected_soft_start      = w[`ACR_BIT_JSOFT];
      c.regular_ext_trig_enable  = w[`ACR_BIT_REXT];
      c.regular_trigger_select   = w[`ACR_POS_RSEL +: 3];
      c.injected_ext_trig_enable = w[`ACR_BIT_JEXT];
      c.injected_trigger_select  = w[`ACR_POS_JSEL +: 3];
      c.result_align_left        = w[`ACR_BIT_ALIGN];
      c.dma_request_enable       = w[`ACR_BIT_DMA];
      c.calibrate_start          = w[`ACR_BIT_CAL];
      c.continuous_mode          = w[`ACR_BIT_CONT];
      c.converter_power          = w[`ACR_BIT_POWER];
      return c;
   endfunction

   // ************************************************************
   // bus and control next state
   // ************************************************************
   logic        wr_hit;
   logic [31:0] old_w;
   logic [31:0] new_w;
   acr_ctrl_t   nc;
   logic        rsoft_go;
   logic        jsoft_go;

   always_comb begin
      st_d     = st_q;
      old_w    = pack_ctrl(st_q.ctrl);
      new_w    = (old_w & ~`ACR_WMASK_CTRL2) | (hwdata & `ACR_WMASK_CTRL2);
      nc       = unpack_ctrl(new_w);
      wr_hit   = st_q.bus.addr_valid && st_q.bus.addr_write
                 && (st_q.bus.addr == `ACR_OFF_CTRL2);
      rsoft_go = 1'b0;
      jsoft_go = 1'b0;

      st_d.reg_start = 1'b0;
      st_d.inj_start = 1'b0;
      st_d.cal_go    = 1'b0;
      st_d.abort     = 1'b0;

      // address phase capture; zero wait states
      st_d.bus.addr_valid = hsel && hready && htrans[1];
      st_d.bus.addr_write = hwrite;
      st_d.bus.addr       = {haddr[11:2], 2'b00};
      if (hsel && hready && htrans[1] && !hwrite) begin
         st_d.rdata = ({haddr[11:2], 2'b00} == `ACR_OFF_CTRL2) ? old_w : 32'h0000_0000;
      end

      if (wr_hit) begin
         // reserved bits are not stored and read back zero
         if (!nc.converter_power) begin
            nc.calibrate_start     = 1'b0;
            nc.regular_soft_start  = 1'b0;
            nc.injected_soft_start = 1'b0;
            st_d.abort             = st_q.ctrl.converter_power;
         end else if (st_q.ctrl.converter_power && (new_w == old_w)) begin
            st_d.reg_start = 1'b1;
         end
         if (nc.calibrate_start && !st_q.ctrl.calibrate_start && nc.converter_power) begin
            st_d.cal_go = 1'b1;
         end
         st_d.ctrl = nc;
      end

      // soft starts fire only with the software code selected
      rsoft_go = st_d.ctrl.regular_soft_start && st_d.ctrl.converter_power
                 && (st_d.ctrl.regular_trigger_select == `ACR_SEL_SOFT);
      jsoft_go = st_d.ctrl.injected_soft_start && st_d.ctrl.converter_power
                 && (st_d.ctrl.injected_trigger_select == `ACR_SEL_SOFT);
      if (rsoft_go && !st_q.reg_start && !wr_hit) begin
         st_d.reg_start = 1'b1;
      end
      if (jsoft_go && !wr_hit) begin
         st_d.inj_start = 1'b1;
      end
      if (st_q.ctrl.converter_power && reg_ext_fire) begin
         st_d.reg_start = 1'b1;
      end
      if (st_q.ctrl.converter_power && inj_ext_fire) begin
         st_d.inj_start = 1'b1;
      end

      // hardware clears; a same-cycle software set via new write still wins
      if (regular_conv_begin && !(wr_hit && !st_q.ctrl.regular_soft_start
                                  && nc.regular_soft_start)) begin
         st_d.ctrl.regular_soft_start = 1'b0;
         st_d.reg_start               = 1'b0;
      end
      if (injected_conv_begin && !(wr_hit && !st_q.ctrl.injected_soft_start
                                   && nc.injected_soft_start)) begin
         st_d.ctrl.injected_soft_start = 1'b0;
         st_d.inj_start                = 1'b0;
      end
      if (calibration_done && !st_d.cal_go) begin
         st_d.ctrl.calibrate_start = 1'b0;
      end

      st_d.sensor_ref_on = st_d.ctrl.sensor_ref_enable;
      st_d.powered       = st_d.ctrl.converter_power;
      st_d.power_down    = !st_d.ctrl.converter_power;
      st_d.cont          = st_d.ctrl.continuous_mode;
      st_d.align         = st_d.ctrl.result_align_left;
      st_d.dma           = st_d.ctrl.dma_request_enable;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q            <= '0;
         st_q.power_down <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign hrdata            = st_q.rdata;
   assign hreadyout         = 1'b1;
   assign hresp             = 1'b0;
   assign sensor_ref_on     = st_q.sensor_ref_on;
   assign converter_powered = st_q.powered;
   assign power_down        = st_q.power_down;
   assign regular_start     = st_q.reg_start;
   assign injected_start    = st_q.inj_start;
   assign calibrate_go      = st_q.cal_go;
   assign abort             = st_q.abort;
   assign continuous        = st_q.cont;
   assign align_left        = st_q.align;
   assign dma_enable        = st_q.dma;
endmodule

// *** sim/acr_ctrl2_monitor.sv ***
`timescale 1ns/1ps
// ****
// port checks, watching design outputs and the two conversion-begin inputs
// ****
module acr_ctrl2_monitor (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic [31:0] hrdata,
   input wire logic        regular_conv_begin,
   input wire logic        injected_conv_begin,
   input wire logic        power_down,
   input wire logic        converter_powered,
   input wire logic        regular_start,
   input wire logic        injected_start,
   input wire logic        calibrate_go,
   input wire logic        abort
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_drop;
      ##[0:1] power_down;
   endsequence
   pwr_level_a: assert property (power_down == !converter_powered)
      else $error("power_down is not the inverse of power");
   abort_off_a: assert property (abort |-> s_drop)
      else $error("abort without power down");
   cal_pwr_a: assert property (calibrate_go |-> converter_powered || $past(converter_powered))
      else $error("calibration launched while off");
   rstart_pwr_a: assert property (regular_start |-> converter_powered || $past(converter_powered))
      else $error("regular start while off");
   jstart_pwr_a: assert property (injected_start |-> converter_powered || $past(converter_powered))
      else $error("injected start while off");
   rbegin_stop_a: assert property (regular_conv_begin |-> ##1 !regular_start)
      else $error("regular start persists after begin");
   jbegin_stop_a: assert property (injected_conv_begin |-> ##1 !injected_start)
      else $error("injected start persists after begin");
   resv_zero_a: assert property ((hrdata & 32'hff01_06f8) == 32'h0)
      else $error("reserved bits read nonzero");
endmodule

// *** sim/acr_core_model.sv ***
`timescale 1ns/1ps
// ****
// conversion core: answers starts after a fast or slow delay
// ****
module acr_core_model (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       slow,
   input  wire logic [2:0] go,
   input  wire logic       abort,
   output logic      [2:0] done
);
   logic [3:0] cnt_q [3];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= '{default: 4'h0};
         done <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            done[i] <= !abort && cnt_q[i] == 4'h1;
            // busy core ignores repeated starts, as the real one would
            if (abort)
               cnt_q[i] <= 4'h0;
            else if (cnt_q[i] != 4'h0)
               cnt_q[i] <= cnt_q[i] - 4'h1;
            else if (go[i])
               cnt_q[i] <= slow ? 4'h8 : 4'h2;
         end
      end
   end
endmodule

// *** sim/test_adc_control_register_two.sv ***
`timescale 1ns/1ps
`include "acr_defs.svh"
module test_adc_control_register_two;
   import acr_pkg::*;
   localparam logic [11:0] A = `ACR_OFF_CTRL2;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, slow = 0;
   logic [11:0] haddr = 0;
   logic [1:0]  htrans = 0;
   logic [31:0] hwdata = 0, hrdata, rd;
   logic [7:0]  rtrig = 0, jtrig = 0;
   logic [2:0]  dn;
   logic        hready, hrsp, sens, pwr, pdn, rs, js, cgo, abt, cont, algn, dma;
   int          n_mismatch = 0, checks = 0, cyc = 0;
   wire  [3:0]  ev = {abt, cgo, js, rs};
   always #2 hclk = ~hclk;
   acr_ctrl2 uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp(hrsp),
      .regular_trig_in(rtrig), .injected_trig_in(jtrig), .regular_conv_begin(dn[0]),
      .injected_conv_begin(dn[1]), .calibration_done(dn[2]), .sensor_ref_on(sens),
      .converter_powered(pwr), .power_down(pdn), .regular_start(rs), .injected_start(js),
      .calibrate_go(cgo), .abort(abt), .continuous(cont), .align_left(algn), .dma_enable(dma));
   acr_core_model u_core (.hclk, .hresetn, .slow, .go({cgo, js, rs}), .abort(abt), .done(dn));
   // ****
   // helpers
   // ****
   task automatic summarize;
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= `ACR_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // pulses are at least one cycle wide, so look once in every cycle
   task automatic evc(input int i, input int n, input logic e);
      logic s;
      s = 1'b0;
      repeat (n) begin
         #1;
         if (ev[i] === 1'b1) s = 1'b1;
         @(posedge hclk);
      end
      chk({31'h0, s}, {31'h0, e});
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_reset;
      rdc(A, `ACR_RESET_CTRL2);
      bus(1'b1, 12'h00c, 32'hffff_ffff);
      rdc(12'h00c, 32'h0);
      chk({hready, hrsp}, 32'h2);
      rdc(A, 32'h0);
      chk(pdn, 1'b1);
   endtask
   task automatic t_fields;
      bus(1'b1, A, 32'h009a_f902);
      rdc(A, 32'h009a_f902);
      chk({sens, algn, dma, cont, pwr}, 5'h1e);
   endtask
   task automatic t_power;
      bus(1'b1, A, 32'h009a_f903);
      evc(0, 6, 1'b0);
      chk(pwr, 1'b1);
      bus(1'b1, A, 32'h009a_f903);
      evc(0, 4, 1'b1);
      repeat (12) @(posedge hclk);
      bus(1'b1, A, 32'h009a_f103);
      evc(0, 6, 1'b0);
      chk(algn, 1'b0);
   endtask
   task automatic t_soft;
      slow <= 1'b1;
      bus(1'b1, A, 32'h000e_0001);
      bus(1'b1, A, 32'h004e_0001);
      evc(0, 4, 1'b1);
      repeat (12) @(posedge hclk);
      rdc(A, 32'h000e_0001);
      bus(1'b1, A, 32'h0000_7001);
      bus(1'b1, A, 32'h0020_7001);
      evc(1, 4, 1'b1);
      repeat (12) @(posedge hclk);
      rdc(A, 32'h0000_7001);
      slow <= 1'b0;
      bus(1'b1, A, 32'h0000_0001);
      bus(1'b1, A, 32'h0060_0001);
      evc(0, 8, 1'b0);
      evc(1, 4, 1'b0);
      bus(1'b1, A, 32'h0000_0001);
      rdc(A, 32'h0000_0001);
   endtask
   task automatic t_ext;
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, A, 32'h0010_8001 | (32'(i) << 17) | (32'(i) << 12));
         rtrig <= 8'h1 << i;
         evc(0, 8, 1'b1);
         rtrig <= 8'h0;
         repeat (10) @(posedge hclk);
         jtrig <= 8'h1 << i;
         evc(1, 8, 1'b1);
         jtrig <= 8'h0;
         repeat (10) @(posedge hclk);
      end
      bus(1'b1, A, 32'h0000_0001);
      rtrig <= 8'h1;
      evc(0, 8, 1'b0);
      jtrig <= 8'h1;
      evc(1, 8, 1'b0);
      rtrig <= 8'h0;
      jtrig <= 8'h0;
   endtask
   task automatic t_cal_off;
      bus(1'b1, A, 32'h0000_0005);
      evc(2, 4, 1'b1);
      repeat (12) @(posedge hclk);
      rdc(A, 32'h0000_0001);
      // second calibration is cut short by powering off
      slow <= 1'b1;
      bus(1'b1, A, 32'h0000_0005);
      bus(1'b1, A, 32'h0);
      evc(3, 4, 1'b1);
      chk(pdn, 1'b1);
      rdc(A, 32'h0);
   endtask
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         summarize();
      end
   end
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_fields();
      t_power();
      t_soft();
      t_ext();
      t_cal_off();
      summarize();
   end
endmodule
bind acr_ctrl2 acr_ctrl2_monitor u_mon (.hclk, .hresetn, .hrdata, .regular_conv_begin,
   .injected_conv_begin, .power_down, .converter_powered, .regular_start, .injected_start,
   .calibrate_go, .abort);
